/* File: rtl/ir_carrier_modulator.v */
// infrared carrier modulator: mark/space timer, gate, output stage and end-of-cycle flag
// assumes register bytes are written by the surrounding register file and held stable
// Notes on behaviour
// - a 17-bit down counter loads mark period with a zero sign bit
// - gate stays open while the counter is not negative, passing the carrier
// - on underflow gate closes; complement of counter compared to space register
// - on match gate reopens, counter and space register reload while enabled, else the timer goes idle
// - a zero space register matches at once, no space interval
// - timer runs while the enable bit is set or a cycle is still active
// - time and baseband count input clock divided by eight; mark is value plus one
// - time mode gates the carrier to the output during marks
// - baseband output is high during mark, low during space
// - dual-carrier mode counts carrier clocks, space follows the mark directly
// - dual-carrier mode swaps primary and secondary sets at each space end
// - zero space in dual-carrier mode switches frequency without gap or glitch
// - extended space makes each period all space from the next reload
// - clearing extended space resumes marks at the next period
// - extended space in dual-carrier still counts carrier and alternates sets
// - enabled or active modulator drives the pin, disabled idle pin follows the latch bit
// - a polarity bit selects active high or active low pin
// - flag sets on enable from idle and on each reload while enabled
// - re-enable before cycle end sets the flag only at that cycle's end
// - no flag at the end of the final cycle after disable
// - flag clears after status read followed by low mark or space access
// - interrupt request while flag and its enable are set
// - carrier bypass holds the carrier to the modulator high
// - with enable clear and the modulator idle the latch bit, through the polarity bit, sets the pin level
`timescale 1ns/10ps
`include "ir_carrier_modulator_map.vh"
module ir_carrier_modulator (
  input  wire                        clock,
  input  wire                        rstn,
  input  wire [`MOD_BYTE_W-1:0]      mark_period_high_byte,
  input  wire [`MOD_BYTE_W-1:0]      mark_period_low_byte,
  input  wire [`MOD_BYTE_W-1:0]      space_period_high_byte,
  input  wire [`MOD_BYTE_W-1:0]      space_period_low_byte,
  input  wire                        modulator_carrier_enable,
  input  wire                        carrier_bypass_select,
  input  wire                        dual_carrier_select,
  input  wire                        extended_space_enable,
  input  wire                        end_of_cycle_irq_enable,
  input  wire                        output_latch_bit,
  input  wire                        output_polarity,
  input  wire                        modulator_input_clock,
  input  wire                        carrier_signal,
  input  wire                        status_read,
  input  wire                        low_byte_access,
  output reg                         infrared_output_pin,
  output reg                         secondary_select,
  output wire                        end_of_cycle_flag,
  output wire                        end_of_cycle_irq,
  output wire                        modulator_active
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_MARK  = 2'h1;
  localparam ST_SPACE = 2'h2;

  reg [1:0]                state_r;
  reg [1:0]                state_nxt;
  reg [`MOD_COUNT_W-1:0]   count_r;
  reg [`MOD_COUNT_W-1:0]   count_nxt;
  reg [`MOD_PERIOD_W-1:0]  space_r;
  reg                      exspace_r;
  reg                      mod_out;
  reg                      reload;
  reg                      start;

  wire                     tick;
  wire                     fsk_mode;
  wire                     gated_carrier;
  wire                     space_match;
  wire [`MOD_PERIOD_W-1:0] mark_val;
  wire [`MOD_PERIOD_W-1:0] space_val;

  assign mark_val  = {mark_period_high_byte, mark_period_low_byte};
  assign space_val = {space_period_high_byte, space_period_low_byte};
  assign fsk_mode  = dual_carrier_select && !carrier_bypass_select;
  assign gated_carrier = carrier_bypass_select ? 1'b1 : carrier_signal;
  // comparator sees the complement of the counter low half
  assign space_match = (~count_r[`MOD_PERIOD_W-1:0]) == space_r;
  assign modulator_active = (state_r != ST_IDLE);

  // counting stays alive after disable so the last cycle completes
  mod_tick_gen u_tick (
    .clock          (clock),
    .rstn           (rstn),
    .run            (modulator_carrier_enable || modulator_active),
    .count_carrier  (fsk_mode),
    .clk_strobe     (modulator_input_clock),
    .carrier_signal (carrier_signal),
    .tick           (tick)
  );

  always @* begin
    state_nxt = state_r;
    count_nxt = count_r;
    reload    = 1'b0;
    start     = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (modulator_carrier_enable) begin
          start     = 1'b1;
          reload    = 1'b1;
          state_nxt = ST_MARK;
          count_nxt = {1'b0, mark_val};
        end
      end
      ST_MARK: begin
        if (tick) begin
          count_nxt = count_r - 17'h00001;
          // underflow sets the sign bit; space starts at once
          if (count_r == `MOD_COUNT_RST)
            state_nxt = ST_SPACE;
        end
      end
      ST_SPACE: begin
        // an all-zero space register matches on entry
        if (space_match) begin
          if (modulator_carrier_enable) begin
            reload    = 1'b1;
            state_nxt = ST_MARK;
            count_nxt = {1'b0, mark_val};
          end else begin
            state_nxt = ST_IDLE;
            count_nxt = `MOD_COUNT_RST;
          end
        end else if (tick) begin
          count_nxt = count_r - 17'h00001;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        count_nxt = `MOD_COUNT_RST;
      end
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r          <= ST_IDLE;
      count_r          <= `MOD_COUNT_RST;
      space_r          <= `MOD_PERIOD_RST;
      exspace_r        <= 1'b0;
      secondary_select <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      if (reload) begin
        space_r   <= space_val;
        exspace_r <= extended_space_enable;
      end
      // swap sets at each period end, also during extended space
      if (state_r == ST_SPACE && space_match && fsk_mode)
        secondary_select <= ~secondary_select;
      else if (state_r == ST_IDLE)
        secondary_select <= 1'b0;
    end
  end

  // modulator output; extended space suppresses the mark
  always @* begin
    if (state_r != ST_MARK || exspace_r)
      mod_out = 1'b0;
    else
      mod_out = gated_carrier;
  end

  // flag only at start from idle or reload while enabled
  eoc_flag u_eoc (
    .clock           (clock),
    .rstn            (rstn),
    // a re-enable inside a running cycle is not a start, so the flag waits
    .set_pulse       (reload && (start || modulator_carrier_enable)),
    .status_read     (status_read),
    .low_byte_access (low_byte_access),
    .irq_enable      (end_of_cycle_irq_enable),
    .flag_r          (end_of_cycle_flag),
    .irq             (end_of_cycle_irq)
  );

  // registered pin; latch xor polarity rules when disabled and idle
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      infrared_output_pin <= 1'b0;
    else if (modulator_carrier_enable || modulator_active)
      infrared_output_pin <= mod_out ^ output_polarity;
    else
      infrared_output_pin <= output_latch_bit ^ output_polarity;
  end
endmodule

/* File: rtl/ir_carrier_modulator_map.vh */
// constants for the infrared carrier modulator: widths, prescale value, reset values
// assumes inclusion by the modulator files and the testbench
`ifndef IR_CARRIER_MODULATOR_MAP_VH
`define IR_CARRIER_MODULATOR_MAP_VH

`define MOD_PERIOD_W     16
`define MOD_COUNT_W      17
`define MOD_PRESCALE     3'h7
`define MOD_PERIOD_RST   16'h0000
`define MOD_COUNT_RST    17'h00000
`define MOD_BYTE_W       8

`endif

/* File: rtl/mod_tick_gen.v */
// tick generator: one pulse every eight modulator input clock pulses, or per carrier rise
// assumes the input clock strobe and carrier are synchronous to clock
`timescale 1ns/10ps
`include "ir_carrier_modulator_map.vh"
module mod_tick_gen (
  input  wire       clock,
  input  wire       rstn,
  input  wire       run,
  input  wire       count_carrier,
  input  wire       clk_strobe,
  input  wire       carrier_signal,
  output wire       tick
);
  reg [2:0] div_r;
  reg       car_d_r;
  wire      div_tick;
  wire      car_tick;

  assign div_tick = clk_strobe && (div_r == `MOD_PRESCALE);
  assign car_tick = carrier_signal && !car_d_r;
  assign tick     = run && (count_carrier ? car_tick : div_tick);

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_r   <= 3'h0;
      car_d_r <= 1'b0;
    end else begin
      car_d_r <= carrier_signal;
      if (!run)
        div_r <= 3'h0;
      else if (clk_strobe)
        div_r <= div_r + 3'h1;
    end
  end
endmodule

/* File: rtl/eoc_flag.v */
// end-of-cycle flag with read-then-access clear and interrupt request
// assumes the bus strobes are single-cycle pulses synchronous to clock
`timescale 1ns/10ps
module eoc_flag (
  input  wire       clock,
  input  wire       rstn,
  input  wire       set_pulse,
  input  wire       status_read,
  input  wire       low_byte_access,
  input  wire       irq_enable,
  output reg        flag_r,
  output wire       irq
);
  reg armed_r;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flag_r  <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      // a set in the clear cycle wins
      if (set_pulse)
        flag_r <= 1'b1;
      else if (armed_r && low_byte_access)
        flag_r <= 1'b0;
      if (status_read && flag_r)
        armed_r <= 1'b1;
      else if (low_byte_access || !flag_r)
        armed_r <= 1'b0;
    end
  end

  assign irq = flag_r && irq_enable;
endmodule

/* File: verif/ir_emitter.sv */
// infrared emitter model: lit while the pin sits at its active level
// assumes the pin and polarity come straight from the modulator
`timescale 1ns/10ps
module ir_emitter (
  input  wire logic pin,
  input  wire logic active_low,
  output wire logic lit
);
  assign lit = pin ^ active_low;
endmodule

/* File: verif/mod_chk.sv */
// port-level checker for the infrared carrier modulator
// assumes single clock domain, bound onto the modulator top module
`timescale 1ns/10ps
module mod_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic modulator_carrier_enable,
  input wire logic carrier_bypass_select,
  input wire logic dual_carrier_select,
  input wire logic end_of_cycle_irq_enable,
  input wire logic output_latch_bit,
  input wire logic output_polarity,
  input wire logic carrier_signal,
  input wire logic low_byte_access,
  input wire logic infrared_output_pin,
  input wire logic secondary_select,
  input wire logic end_of_cycle_flag,
  input wire logic end_of_cycle_irq,
  input wire logic modulator_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_IDLE_PIN:
    assert property (!modulator_active && !modulator_carrier_enable |=> infrared_output_pin
      == ($past(output_latch_bit) ^ $past(output_polarity))) else $error("idle pin wrong");
  AST_TIME_GATE:
    assert property (modulator_active && modulator_carrier_enable && !carrier_bypass_select
      && !carrier_signal |=> infrared_output_pin == output_polarity) else $error("gate leak");
  AST_FLAG_CLEAR:
    assert property ($fell(end_of_cycle_flag) |-> $past(low_byte_access))
      else $error("flag cleared without access");
  AST_FLAG_RISE:
    assert property ($rose(end_of_cycle_flag) |-> modulator_active
      && $past(modulator_carrier_enable)) else $error("flag set while disabled");
  AST_IRQ:
    assert property (end_of_cycle_irq == (end_of_cycle_flag && end_of_cycle_irq_enable))
      else $error("irq mismatch");
  AST_NO_RUN:
    assert property (!modulator_active && !modulator_carrier_enable |=> !modulator_active)
      else $error("timer ran while disabled");
  AST_START:
    assert property (!modulator_active && modulator_carrier_enable |=> modulator_active
      && end_of_cycle_flag) else $error("start missed");
  AST_SEL_HOLD:
    assert property ($changed(secondary_select) |-> $past(dual_carrier_select)
      && !$past(carrier_bypass_select)) else $error("set swap outside dual mode");
  cover property ($rose(end_of_cycle_flag));
  cover property ($changed(secondary_select));
  cover property ($fell(end_of_cycle_flag));
endmodule
bind ir_carrier_modulator mod_chk mod_chk_i (.*);

/* File: verif/tb.sv */
// testbench for the infrared carrier modulator: baseband, extended space, dual carrier
// assumes a free-running input clock strobe and a carrier of two clock periods
`timescale 1ns/10ps
`include "ir_carrier_modulator_map.vh"
module tb;
  logic [`MOD_BYTE_W-1:0] mark_hi = 8'h00, mark_lo = 8'h02, space_hi = 8'h00, space_lo = 8'h03;
  logic en = 1'b0, bypass = 1'b0, dual = 1'b0, ext = 1'b0, irq_en = 1'b0, latch = 1'b1;
  logic pol = 1'b0, strobe = 1'b1, carrier = 1'b0, rd = 1'b0, acc = 1'b0;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic pin, sec, flag, irq, active, lit, s0;
  int   miscompares = 0, checks_done = 0, n, k, i;
  always #20 clock = ~clock;
  always @(posedge clock) carrier <= ~carrier;
  ir_carrier_modulator ir_carrier_modulator_i (.clock(clock), .rstn(rstn),
    .mark_period_high_byte(mark_hi), .mark_period_low_byte(mark_lo),
    .space_period_high_byte(space_hi), .space_period_low_byte(space_lo),
    .modulator_carrier_enable(en), .carrier_bypass_select(bypass), .dual_carrier_select(dual),
    .extended_space_enable(ext), .end_of_cycle_irq_enable(irq_en), .output_latch_bit(latch),
    .output_polarity(pol), .modulator_input_clock(strobe), .carrier_signal(carrier),
    .status_read(rd), .low_byte_access(acc), .infrared_output_pin(pin),
    .secondary_select(sec), .end_of_cycle_flag(flag), .end_of_cycle_irq(irq),
    .modulator_active(active));
  ir_emitter ir_emitter_i (.pin(pin), .active_low(pol), .lit(lit));
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // bounded wait: a spent bound is a mismatch and ends the run
  task automatic bail(input int cnt, input string what);
    if (cnt >= 400) begin
      check(what, 0, 1);
      conclude();
    end
  endtask
  // length in cycles of the next full interval at which lit equals lvl
  task automatic span(input logic lvl, output int cnt);
    for (k = 0; k < 400 && lit === lvl; k++) @(posedge clock);
    for (k = 0; k < 400 && lit !== lvl; k++) @(posedge clock);
    bail(k, "interval start");
    for (cnt = 0; cnt < 400 && lit === lvl; cnt++) @(posedge clock);
    bail(cnt, "interval end");
  endtask
  task automatic pulse(input bit do_read);
    @(posedge clock);
    if (do_read) rd <= 1'b1;
    else acc <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    acc <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    check("idle pin", pin, 1);
    pol <= 1'b1;
    repeat (3) @(posedge clock);
    check("inverted idle pin", pin, 0);
    pol <= 1'b0;
    latch <= 1'b0;
    bypass <= 1'b1;
    irq_en <= 1'b1;
    en <= 1'b1;
    @(posedge clock);
    #1 check("start flag", flag, 1);
    check("irq", irq, 1);
    span(1'b1, n);
    check("mark ticks", (n + 4) / 8, 3);
    span(1'b0, n);
    check("space ticks", (n + 4) / 8, 3);
    pulse(1'b0);
    #1 check("flag kept", flag, 1);
    pulse(1'b1);
    pulse(1'b0);
    #1 check("flag cleared", flag, 0);
    ext <= 1'b1;
    repeat (120) @(posedge clock);
    for (n = 0, i = 0; i < 100; i++) @(posedge clock) n += lit;
    check("extended space marks", n, 0);
    ext <= 1'b0;
    span(1'b1, n);
    check("mark resumes", (n + 4) / 8, 3);
    en <= 1'b0;
    pulse(1'b1);
    pulse(1'b0);
    for (k = 0; k < 400 && active !== 1'b0; k++) @(posedge clock);
    bail(k, "idle");
    repeat (2) @(posedge clock);
    check("no final flag", flag, 0);
    check("latch pin", pin, 0);
    bypass <= 1'b0;
    dual <= 1'b1;
    space_lo <= 8'h00;
    en <= 1'b1;
    for (i = 0; i < 3; i++) begin
      s0 = sec;
      for (k = 0; k < 40 && sec === s0; k++) @(posedge clock);
      check("carrier set swap", sec, !s0);
    end
    // a long mark leaves room to clear the flag and re-enable inside one cycle
    mark_lo <= 8'h20;
    s0 = sec;
    for (k = 0; k < 40 && sec === s0; k++) @(posedge clock);
    check("carrier set swap", sec, !s0);
    pulse(1'b1);
    pulse(1'b0);
    en <= 1'b0;
    @(posedge clock);
    en <= 1'b1;
    @(posedge clock);
    #1 check("no flag on re-enable", flag, 0);
    for (k = 0; k < 120 && flag !== 1'b1; k++) @(posedge clock);
    check("flag at cycle end", flag, 1);
    conclude();
  end
endmodule
